// File: rtl/pfx_pkg.sv
// Purpose: Constants and types shared by the pointer/flag/translate decoder
// Assumes: 8-bit opcode bytes, 16-bit registers, one core clock
// Notes:   Clock counts are the full instruction times, first byte to done, except CLK_INVALID: clocks left after the modrm byte
package pfx_pkg;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_LOAD_EA             = 8'h8D;
  localparam logic [7:0] OP_LOAD_DATA_SEG_PTR   = 8'hC5;
  localparam logic [7:0] OP_LOAD_EXTRA_SEG_PTR  = 8'hC4;
  localparam logic [7:0] OP_FLAGS_TO_ACC_HIGH   = 8'h9F;
  localparam logic [7:0] OP_ACC_HIGH_TO_FLAGS   = 8'h9E;
  localparam logic [7:0] OP_PUSH_FLAGS          = 8'h9C;
  localparam logic [7:0] OP_XLATE               = 8'hD7;

  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int         MOD_HI           = 7;
  localparam int         MOD_LO           = 6;
  localparam int         REG_HI           = 5;
  localparam int         REG_LO           = 3;
  localparam logic [1:0] MOD_REGISTER     = 2'h3;

  // ****************************************
  // Clock counts
  // ****************************************
  localparam logic [4:0] CLK_LOAD_EA            = 5'h06;
  localparam logic [4:0] CLK_LOAD_PTR           = 5'h1A;
  localparam logic [4:0] CLK_FLAGS_TO_ACC_HIGH  = 5'h02;
  localparam logic [4:0] CLK_ACC_HIGH_TO_FLAGS  = 5'h03;
  localparam logic [4:0] CLK_PUSH_FLAGS         = 5'h0D;
  localparam logic [4:0] CLK_XLATE              = 5'h0F;
  localparam logic [4:0] CLK_INVALID            = 5'h01;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    PFX_OP_NONE,
    PFX_OP_LOAD_EA,
    PFX_OP_LOAD_DATA_SEG_PTR,
    PFX_OP_LOAD_EXTRA_SEG_PTR,
    PFX_OP_FLAGS_TO_ACC_HIGH,
    PFX_OP_ACC_HIGH_TO_FLAGS,
    PFX_OP_PUSH_FLAGS,
    PFX_OP_XLATE
  } pfx_op_e;

  typedef enum logic [1:0] {
    PFX_ST_IDLE,
    PFX_ST_MODRM,
    PFX_ST_EXEC
  } pfx_state_e;

endpackage : pfx_pkg

// File: rtl/pfx_dec_if.sv
// Purpose: Carries a classified opcode from the matcher to the sequencer
// Assumes: Purely combinational classification
// Notes:   The top drives the byte, the matcher returns the class
`timescale 1ns/100ps
interface pfx_dec_if;
  import pfx_pkg::*;
  logic [7:0] opcode;
  pfx_op_e    op;
  logic       needs_modrm;
  logic       ptr_load;
  logic [4:0] clocks;

  modport matcher (input opcode, output op, needs_modrm, ptr_load, clocks);
  modport user    (output opcode, input op, needs_modrm, ptr_load, clocks);
endinterface : pfx_dec_if

// File: rtl/pfx_opcode_match.sv
// Purpose: Match a first opcode byte to one instruction of the group
// Assumes: Opcode is stable while it is examined
// Notes:   Unknown bytes classify as none with zero clocks
`timescale 1ns/100ps
module pfx_opcode_match
  import pfx_pkg::*;
(
  pfx_dec_if.matcher dec
);

  // Fixed first-byte compare, no modrm dependence here
  always_comb begin
    dec.op          = PFX_OP_NONE;
    dec.needs_modrm = 1'b0;
    dec.ptr_load    = 1'b0;
    dec.clocks      = 5'h00;
    unique case (dec.opcode)
      OP_LOAD_EA: begin
        dec.op          = PFX_OP_LOAD_EA;
        dec.needs_modrm = 1'b1;
        dec.clocks      = CLK_LOAD_EA;
      end
      OP_LOAD_DATA_SEG_PTR: begin
        dec.op          = PFX_OP_LOAD_DATA_SEG_PTR;
        dec.needs_modrm = 1'b1;
        dec.ptr_load    = 1'b1;
        dec.clocks      = CLK_LOAD_PTR;
      end
      OP_LOAD_EXTRA_SEG_PTR: begin
        dec.op          = PFX_OP_LOAD_EXTRA_SEG_PTR;
        dec.needs_modrm = 1'b1;
        dec.ptr_load    = 1'b1;
        dec.clocks      = CLK_LOAD_PTR;
      end
      OP_FLAGS_TO_ACC_HIGH: begin
        dec.op     = PFX_OP_FLAGS_TO_ACC_HIGH;
        dec.clocks = CLK_FLAGS_TO_ACC_HIGH;
      end
      OP_ACC_HIGH_TO_FLAGS: begin
        dec.op     = PFX_OP_ACC_HIGH_TO_FLAGS;
        dec.clocks = CLK_ACC_HIGH_TO_FLAGS;
      end
      OP_PUSH_FLAGS: begin
        dec.op     = PFX_OP_PUSH_FLAGS;
        dec.clocks = CLK_PUSH_FLAGS;
      end
      OP_XLATE: begin
        dec.op     = PFX_OP_XLATE;
        dec.clocks = CLK_XLATE;
      end
      default: begin
        dec.op = PFX_OP_NONE;
      end
    endcase
  end

endmodule : pfx_opcode_match

// File: rtl/pfx_decode.sv
// Purpose: Decode and time the pointer, flag and translate instructions
// Assumes: Fetch offers one byte per clock with valid/ready; datapath
//          supplies effective address, memory words, flags and registers
// Notes:   Notes on behaviour
`timescale 1ns/100ps
module pfx_decode
  import pfx_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_byte_valid,
  input  wire logic [7:0]  i_byte,
  output      logic        o_byte_ready,
  input  wire logic [15:0] i_eff_addr,
  input  wire logic [15:0] i_mem_offset,
  input  wire logic [15:0] i_mem_segment,
  input  wire logic [15:0] i_flag_word,
  input  wire logic [15:0] i_acc,
  input  wire logic [15:0] i_table_base,
  input  wire logic [7:0]  i_table_byte,
  output      logic [15:0] o_table_addr,
  output      logic        o_busy,
  output      logic        o_done,
  output      logic        o_invalid,
  output      logic [2:0]  o_op,
  output      logic        o_reg_we,
  output      logic [2:0]  o_reg_sel,
  output      logic [15:0] o_reg_data,
  output      logic        o_data_segment_we,
  output      logic        o_extra_segment_we,
  output      logic [15:0] o_segment_data,
  output      logic        o_accumulator_high_byte_we,
  output      logic        o_accumulator_low_byte_we,
  output      logic [7:0]  o_acc_byte_data,
  output      logic        o_flags_low_we,
  output      logic [7:0]  o_flags_low_data,
  output      logic        o_push_we,
  output      logic [15:0] o_push_data
);

  // ****************************************
  // Opcode classification
  // ****************************************
  pfx_dec_if dec ();

  assign dec.opcode = i_byte;

  pfx_opcode_match u_match (
    .dec (dec)
  );

  // ****************************************
  // Sequencer state
  // ****************************************
  pfx_state_e state_r;
  pfx_op_e    op_r;
  logic [4:0] count_r;
  logic [2:0] reg_sel_r;

  // One byte per clock; stall fetch while an instruction executes
  assign o_byte_ready = (state_r != PFX_ST_EXEC);
  assign o_busy       = (state_r != PFX_ST_IDLE);
  assign o_op         = op_r;
  assign o_table_addr = i_table_base + {8'h00, i_acc[7:0]};

  function automatic logic is_last(input logic [4:0] cnt);
    is_last = (cnt == 5'h01);
  endfunction : is_last

  // Pointer loads have no register form; the address load accepts any mod
  function automatic logic is_bad_form(input pfx_op_e op, input logic [7:0] modrm);
    is_bad_form = (op != PFX_OP_LOAD_EA) && (modrm[MOD_HI:MOD_LO] == MOD_REGISTER);
  endfunction : is_bad_form

  wire take     = i_byte_valid && o_byte_ready;
  wire finish   = (state_r == PFX_ST_EXEC) && is_last(count_r);

  // State walk: idle -> (modrm) -> exec counting down to last clock
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r   <= PFX_ST_IDLE;
      op_r      <= PFX_OP_NONE;
      count_r   <= 5'h00;
      reg_sel_r <= 3'h0;
    end else begin
      unique case (state_r)
        PFX_ST_IDLE: begin
          if (take && dec.op != PFX_OP_NONE) begin
            op_r <= dec.op;
            // First byte clock counts toward the total
            count_r <= dec.clocks - 5'h01;
            if (dec.needs_modrm) begin
              state_r <= PFX_ST_MODRM;
            end else if (dec.clocks == 5'h01) begin
              state_r <= PFX_ST_IDLE;
            end else begin
              state_r <= PFX_ST_EXEC;
            end
          end
        end
        PFX_ST_MODRM: begin
          if (take) begin
            reg_sel_r <= i_byte[REG_HI:REG_LO];
            // Register form of a pointer load ends after one clock
            if (is_bad_form(op_r, i_byte)) begin
              count_r <= CLK_INVALID;
            end else begin
              count_r <= count_r - 5'h01;
            end
            state_r <= PFX_ST_EXEC;
          end
        end
        PFX_ST_EXEC: begin
          // Count runs down; the last clock raises the strobes
          count_r <= count_r - 5'h01;
          if (is_last(count_r)) begin
            state_r <= PFX_ST_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Invalid encoding marker
  // ****************************************
  // Held from the modrm byte to the end of the sequence, so the
  // strobes stay quiet on the final clock
  logic bad_r;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bad_r <= 1'b0;
    end else if (state_r == PFX_ST_MODRM && take) begin
      bad_r <= is_bad_form(op_r, i_byte);
    end else if (state_r == PFX_ST_IDLE) begin
      bad_r <= 1'b0;
    end
  end

  // ****************************************
  // Completion strobes and write data
  // ****************************************
  // All effects land on the final clock, one pulse, so the datapath
  // sees a single commit point; limitation: inputs sampled on that clock
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_done                     <= 1'b0;
      o_invalid                  <= 1'b0;
      o_reg_we                   <= 1'b0;
      o_reg_sel                  <= 3'h0;
      o_reg_data                 <= 16'h0000;
      o_data_segment_we          <= 1'b0;
      o_extra_segment_we         <= 1'b0;
      o_segment_data             <= 16'h0000;
      o_accumulator_high_byte_we <= 1'b0;
      o_accumulator_low_byte_we  <= 1'b0;
      o_acc_byte_data            <= 8'h00;
      o_flags_low_we             <= 1'b0;
      o_flags_low_data           <= 8'h00;
      o_push_we                  <= 1'b0;
      o_push_data                <= 16'h0000;
    end else begin
      o_done                     <= finish;
      o_invalid                  <= finish && bad_r;
      o_reg_we                   <= 1'b0;
      o_data_segment_we          <= 1'b0;
      o_extra_segment_we         <= 1'b0;
      o_accumulator_high_byte_we <= 1'b0;
      o_accumulator_low_byte_we  <= 1'b0;
      o_flags_low_we             <= 1'b0;
      o_push_we                  <= 1'b0;
      if (finish && !bad_r) begin
        o_reg_sel <= reg_sel_r;
        unique case (op_r)
          PFX_OP_LOAD_EA: begin
            o_reg_we   <= 1'b1;
            o_reg_data <= i_eff_addr;
          end
          PFX_OP_LOAD_DATA_SEG_PTR: begin
            o_reg_we          <= 1'b1;
            o_reg_data        <= i_mem_offset;
            o_data_segment_we <= 1'b1;
            o_segment_data    <= i_mem_segment;
          end
          PFX_OP_LOAD_EXTRA_SEG_PTR: begin
            o_reg_we           <= 1'b1;
            o_reg_data         <= i_mem_offset;
            o_extra_segment_we <= 1'b1;
            o_segment_data     <= i_mem_segment;
          end
          PFX_OP_FLAGS_TO_ACC_HIGH: begin
            o_accumulator_high_byte_we <= 1'b1;
            o_acc_byte_data            <= i_flag_word[7:0];
          end
          PFX_OP_ACC_HIGH_TO_FLAGS: begin
            o_flags_low_we   <= 1'b1;
            o_flags_low_data <= i_acc[15:8];
          end
          PFX_OP_PUSH_FLAGS: begin
            o_push_we   <= 1'b1;
            o_push_data <= i_flag_word;
          end
          PFX_OP_XLATE: begin
            o_accumulator_low_byte_we <= 1'b1;
            o_acc_byte_data           <= i_table_byte;
          end
          default: begin
            o_reg_we <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : pfx_decode

// File: verif/pfx_datapath_model.sv
// Purpose: Datapath and lookup table seen by the decoder
// Assumes: Register and memory words stay fixed for the run
// Notes:   Table byte follows the address, so a wrong address shows
`timescale 1ns/100ps
module pfx_datapath_model (
  input  wire logic [15:0] i_table_addr,
  output      logic [15:0] o_eff_addr,
  output      logic [15:0] o_mem_offset,
  output      logic [15:0] o_mem_segment,
  output      logic [15:0] o_flag_word,
  output      logic [15:0] o_acc,
  output      logic [15:0] o_table_base,
  output      logic [7:0]  o_table_byte
);
  // ****************************************
  // Fixed words, distinct bytes except the two equal bytes of the segment word
  // ****************************************
  assign o_eff_addr    = 16'h1234;
  assign o_mem_offset  = 16'hA55A;
  assign o_mem_segment = 16'h3C3C;
  assign o_flag_word   = 16'h8AD5;
  assign o_acc         = 16'h7E21;
  assign o_table_base  = 16'h0100;
  // Inverted low address byte as content
  assign o_table_byte  = ~i_table_addr[7:0];
endmodule : pfx_datapath_model

// File: verif/pfx_decode_props.sv
// Purpose: Timing and result checks at the decoder ports
// Assumes: One clock, asynchronous active-low reset
// Notes:   A first byte is taken while busy is low
`timescale 1ns/100ps
module pfx_decode_props
  import pfx_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  input wire logic        i_byte_valid,
  input wire logic [7:0]  i_byte,
  input wire logic        o_byte_ready,
  input wire logic [15:0] i_eff_addr,
  input wire logic [15:0] i_mem_offset,
  input wire logic [15:0] i_flag_word,
  input wire logic [15:0] i_acc,
  input wire logic [7:0]  i_table_byte,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic        o_invalid,
  input wire logic        o_reg_we,
  input wire logic [15:0] o_reg_data,
  input wire logic        o_data_segment_we,
  input wire logic        o_extra_segment_we,
  input wire logic        o_accumulator_high_byte_we,
  input wire logic        o_accumulator_low_byte_we,
  input wire logic [7:0]  o_acc_byte_data,
  input wire logic        o_flags_low_we,
  input wire logic [7:0]  o_flags_low_data,
  input wire logic        o_push_we
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic take;
  logic mtake;
  // First byte and modrm byte acceptance
  assign take  = i_byte_valid && !o_busy;
  assign mtake = i_byte_valid && o_byte_ready && o_busy;

  AST_FLAGS_TO_ACC_HIGH: assert property (take && i_byte == OP_FLAGS_TO_ACC_HIGH |-> ##2
    o_done && o_accumulator_high_byte_we && o_acc_byte_data == $past(i_flag_word[7:0]))
    else $error("flags to acc high wrong");
  AST_ACC_HIGH_TO_FLAGS: assert property (take && i_byte == OP_ACC_HIGH_TO_FLAGS |-> ##3
    o_done && o_flags_low_we && o_flags_low_data == $past(i_acc[15:8]))
    else $error("acc high to flags wrong");
  AST_PUSH: assert property (take && i_byte == OP_PUSH_FLAGS |-> ##13 o_done && o_push_we)
    else $error("flag push wrong");
  AST_XLATE: assert property (take && i_byte == OP_XLATE |-> ##15
    o_done && o_accumulator_low_byte_we && o_acc_byte_data == $past(i_table_byte))
    else $error("translate wrong");
  AST_LOAD_EA: assert property (take && i_byte == OP_LOAD_EA ##1 mtake |-> ##5
    o_done && o_reg_we && o_reg_data == $past(i_eff_addr))
    else $error("address load wrong");
  AST_DATA_SEG_PTR: assert property (take && i_byte == OP_LOAD_DATA_SEG_PTR ##1
    mtake && i_byte[7:6] != MOD_REGISTER |-> ##25 o_done && o_data_segment_we &&
    !o_extra_segment_we && o_reg_data == $past(i_mem_offset))
    else $error("data segment pointer wrong");
  AST_EXTRA_SEG_PTR: assert property (take && i_byte == OP_LOAD_EXTRA_SEG_PTR ##1
    mtake && i_byte[7:6] != MOD_REGISTER |-> ##25 o_done && o_extra_segment_we &&
    !o_data_segment_we && o_reg_data == $past(i_mem_offset))
    else $error("extra segment pointer wrong");
  AST_INVALID: assert property (take && (i_byte == OP_LOAD_DATA_SEG_PTR ||
    i_byte == OP_LOAD_EXTRA_SEG_PTR) ##1 mtake && i_byte[7:6] == MOD_REGISTER |-> ##2
    o_done && o_invalid && !o_reg_we && !o_data_segment_we && !o_extra_segment_we)
    else $error("invalid pointer load not flagged");
endmodule : pfx_decode_props

bind pfx_decode pfx_decode_props u_props (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_byte_valid(i_byte_valid), .i_byte(i_byte), .o_byte_ready(o_byte_ready),
  .i_eff_addr(i_eff_addr), .i_mem_offset(i_mem_offset), .i_flag_word(i_flag_word),
  .i_acc(i_acc), .i_table_byte(i_table_byte), .o_busy(o_busy), .o_done(o_done),
  .o_invalid(o_invalid), .o_reg_we(o_reg_we), .o_reg_data(o_reg_data),
  .o_data_segment_we(o_data_segment_we), .o_extra_segment_we(o_extra_segment_we),
  .o_accumulator_high_byte_we(o_accumulator_high_byte_we),
  .o_accumulator_low_byte_we(o_accumulator_low_byte_we),
  .o_acc_byte_data(o_acc_byte_data), .o_flags_low_we(o_flags_low_we),
  .o_flags_low_data(o_flags_low_data), .o_push_we(o_push_we));

// File: verif/test_pointer_flag_xlate_decode.sv
// Purpose: Self-checking run over every instruction of the group
// Assumes: Datapath words come from the partner model
// Notes:   Counts are measured from the edge that takes the first byte
`timescale 1ns/100ps
module test_pointer_flag_xlate_decode
  import pfx_pkg::*;
;
  logic        i_ref_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_byte_valid = 1'b0;
  logic [7:0]  i_byte = 8'h00;
  logic [15:0] eff, off, seg, flg, acc, base, taddr, reg_d, seg_d, push_d;
  logic [7:0]  tbl, accb, flb;
  logic [2:0]  op, sel;
  logic        rdy, busy, done, inval, reg_we, dseg_we, eseg_we, acc_hi_we, acc_lo_we;
  logic        fl_we, push_we;
  logic [1:0]  early = 2'h0;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;

  pfx_datapath_model u_dp (.i_table_addr(taddr), .o_eff_addr(eff), .o_mem_offset(off),
    .o_mem_segment(seg), .o_flag_word(flg), .o_acc(acc), .o_table_base(base),
    .o_table_byte(tbl));
  pfx_decode uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_byte_valid(i_byte_valid),
    .i_byte(i_byte), .o_byte_ready(rdy), .i_eff_addr(eff), .i_mem_offset(off),
    .i_mem_segment(seg), .i_flag_word(flg), .i_acc(acc), .i_table_base(base),
    .i_table_byte(tbl), .o_table_addr(taddr), .o_busy(busy), .o_done(done),
    .o_invalid(inval), .o_op(op), .o_reg_we(reg_we), .o_reg_sel(sel), .o_reg_data(reg_d),
    .o_data_segment_we(dseg_we), .o_extra_segment_we(eseg_we), .o_segment_data(seg_d),
    .o_accumulator_high_byte_we(acc_hi_we), .o_accumulator_low_byte_we(acc_lo_we),
    .o_acc_byte_data(accb), .o_flags_low_we(fl_we), .o_flags_low_data(flb),
    .o_push_we(push_we), .o_push_data(push_d));

  // ****************************************
  // Clock, hang guard, checking
  // ****************************************
  always #20 i_ref_clk = ~i_ref_clk;

  // Run needs under two hundred cycles
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      final_report();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task final_report;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // Offer opcode, modrm after gap idle cycles, measure clocks to done
  task run(input logic [7:0] opc, input logic [7:0] mrm, input logic two, input int gap,
           input int n);
    int k;
    @(posedge i_ref_clk);
    i_byte_valid <= 1'b1;
    i_byte <= opc;
    for (k = 0; k < 40; k++) begin
      @(posedge i_ref_clk);
      i_byte_valid <= two && (k == gap);
      i_byte <= mrm;
      #1;
      // Busy and ready just after the first byte edge
      if (k == 0) early = {busy, rdy};
      if (done === 1'b1) break;
    end
    chk(k + 1, n);
  endtask : run

  // ****************************************
  // Scenarios
  // ****************************************
  task t_flags;
    run(OP_FLAGS_TO_ACC_HIGH, 8'h00, 1'b0, 0, 2);
    chk(acc_hi_we, 1'b1);
    chk(accb, 8'hD5);
    chk(op, 3'h4);
    chk(early, 2'h2);
    chk({busy, rdy}, 2'h1);
    run(OP_ACC_HIGH_TO_FLAGS, 8'h00, 1'b0, 0, 3);
    chk(flb, 8'h7E);
    chk(fl_we, 1'b1);
    run(OP_PUSH_FLAGS, 8'h00, 1'b0, 0, 13);
    chk(push_d, 16'h8AD5);
    chk(push_we, 1'b1);
  endtask : t_flags

  // One bit off the address load opcode must be ignored
  task t_table_lookup_translate_ea;
    run(OP_XLATE, 8'h00, 1'b0, 0, 15);
    chk({acc_lo_we, accb}, 9'h1DE);
    chk(taddr, 16'h0121);
    run(OP_LOAD_EA, 8'h5B, 1'b1, 0, 6);
    chk({reg_we, sel, reg_d}, 20'hB1234);
    chk(early, 2'h3);
    run(8'h8C, 8'h5B, 1'b1, 0, 41);
    chk(early, 2'h1);
  endtask : t_table_lookup_translate_ea

  // Second load stalls its modrm two cycles
  task t_ptr;
    run(OP_LOAD_DATA_SEG_PTR, 8'h96, 1'b1, 0, 26);
    chk({dseg_we, eseg_we, inval, sel}, 6'h22);
    chk({reg_d, seg_d}, 32'hA55A3C3C);
    run(OP_LOAD_EXTRA_SEG_PTR, 8'h0E, 1'b1, 2, 28);
    chk({dseg_we, eseg_we, inval, sel}, 6'h11);
    chk(early, 2'h3);
    run(OP_LOAD_EXTRA_SEG_PTR, 8'h7F, 1'b1, 0, 26);
    chk({dseg_we, eseg_we, inval, sel}, 6'h17);
    chk(reg_we, 1'b1);
    chk({reg_d, seg_d}, 32'hA55A3C3C);
  endtask : t_ptr

  task t_inval;
    run(OP_LOAD_DATA_SEG_PTR, 8'hC8, 1'b1, 0, 3);
    chk({inval, reg_we, dseg_we, eseg_we}, 4'h8);
    run(OP_LOAD_EXTRA_SEG_PTR, 8'hD0, 1'b1, 0, 3);
    chk({inval, reg_we, dseg_we, eseg_we}, 4'h8);
  endtask : t_inval

  // Main sequence
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    t_flags();
    t_table_lookup_translate_ea();
    t_ptr();
    t_inval();
    final_report();
  end
endmodule : test_pointer_flag_xlate_decode
